// file: hw/uam_pkg.sv
// Constants shared by the usage accumulator and meter scaling block.
// Assumes a single 25 MHz clock and an AXI4-Lite register port.
package uam_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_ENERGY_CLR = 8'h00;
   localparam logic [7:0] REG_RUN_CLR = 8'h04;
   localparam logic [7:0] REG_DEC_SEL = 8'h08;
   localparam logic [7:0] REG_DISP_SEL = 8'h0c;
   localparam logic [7:0] REG_FREQ_FS = 8'h10;
   localparam logic [7:0] REG_CUR_FS = 8'h14;
   localparam logic [7:0] REG_ZERO_TRIM = 8'h18;
   localparam logic [7:0] REG_GAIN_TRIM = 8'h1c;
   localparam logic [7:0] REG_USER_GRP = 8'h20;
   localparam logic [7:0] REG_WR_PROT = 8'h24;
   localparam logic [7:0] REG_METER_ITEM = 8'h28;
   localparam logic [7:0] REG_ENERGY = 8'h2c;
   localparam logic [7:0] REG_PON_HRS = 8'h30;
   localparam logic [7:0] REG_RUN_HRS = 8'h34;
   localparam logic [7:0] REG_PON_TALLY = 8'h38;
   localparam logic [7:0] REG_RUN_TALLY = 8'h3c;
   // Parameter codes
   localparam logic [15:0] CODE_OFF = 16'h270f;
   localparam logic [15:0] CODE_TEN = 16'h000a;
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_ONE = 16'h0001;
   localparam logic [15:0] SEL_PON = 16'h0014;
   localparam logic [15:0] SEL_RUN = 16'h0017;
   localparam logic [15:0] SEL_ENERGY = 16'h0019;
   localparam logic [15:0] ITEM_FREQ = 16'h0001;
   localparam logic [15:0] ITEM_CUR = 16'h0002;
   // Reset values and limits, frequency 0.01 Hz, current 0.01 A
   localparam logic [15:0] FREQ_FS_RST = 16'h1388;
   localparam logic [15:0] FREQ_FS_MAX = 16'h9c40;
   localparam logic [15:0] CUR_FS_MAX = 16'hc350;
   localparam logic [15:0] ZERO_TRIM_RST = 16'h03e8;
   localparam logic [15:0] ZERO_TRIM_MIN = 16'h03ca;
   localparam logic [15:0] ZERO_TRIM_MAX = 16'h04b0;
   localparam logic [15:0] GAIN_TRIM_RST = 16'h03e8;
   localparam logic [15:0] GAIN_TRIM_MAX = 16'h07d0;
   // Meter output in mV
   localparam int METER_FS_MV = 10000;
   localparam int METER_MIN_MV = -100;
   localparam int TRIM_STEP_MV = 5;
   localparam int TRIM_CENTRE = 1000;
   // Energy in 0.01 kWh; one unit is 3600 x 0.01 kW x 1 s
   localparam logic [19:0] ENERGY_MAX = 20'hf423f;
   localparam logic [19:0] ENERGY_TWO_DP = 20'h02710;
   localparam logic [19:0] ENERGY_ONE_DP = 20'h186a0;
   localparam logic [15:0] COMM_TEN_MAX = 16'h270f;
   localparam int KWS_PER_UNIT = 3600;
   // Time base
   localparam int CLK_PERIOD_NS = 40;
   localparam int SEC_NS = 1000000000;
   localparam int CYC_PER_SEC = SEC_NS / CLK_PERIOD_NS;
   localparam int SEC_PER_HOUR = 3600;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: hw/uam_hour_ctr.sv
// One hour counter with its own wrap tally.
// Assumes a one-cycle hour tick from the caller's time base.
`timescale 1ns/1ps
`default_nettype none
module uam_hour_ctr #(
   parameter int WIDTH = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic clr,
   output logic [WIDTH-1:0] hours_ff,
   output logic [WIDTH-1:0] tally_ff
);
   localparam logic [WIDTH-1:0] ALL_ONES = '1;
   wire wrap = tick && (hours_ff == ALL_ONES);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hours_ff <= '0;
      end else if (clr) begin
         hours_ff <= '0; // R09
      end else if (tick) begin
         hours_ff <= hours_ff + 1'b1; // R07
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tally_ff <= '0;
      end else if (wrap && !clr) begin
         tally_ff <= tally_ff + 1'b1; // R08
      end
   end

   step_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tick && !clr && hours_ff != ALL_ONES |=> hours_ff == $past(hours_ff) + 1'b1)
      else $error("hour count missed a tick"); // R05
   wrap_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wrap && !clr |=> hours_ff == '0 && tally_ff == $past(tally_ff) + 1'b1)
      else $error("wrap not counted"); // R08
   hold_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !tick && !clr |=> $stable(hours_ff))
      else $error("hour count moved without tick"); // R06
   clear_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clr |=> hours_ff == '0)
      else $error("clear ignored"); // R09
endmodule // uam_hour_ctr
`default_nettype wire

// file: hw/uam_top.sv
// Energy and hour accumulators, panel formatting and meter scaling.
// Assumes drive-side monitor inputs are on aclk; registers via AXI4-Lite.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R01: Energy sums output power; shown total refreshes once per hour.
// R02: Energy up to 9999.99 kWh on four digits, resolution by size.
// R03: Writing zero to energy clear parameter zeroes the energy total.
// R04: Energy clear parameter reads back its range mode, 9999 or 10.
// R05: Power-on hours advance once per energized hour.
// R06: Running hours advance only while the drive runs.
// R07: Each hour counter wraps past 65535 to zero.
// R08: Each hour counter has a readable wrap tally.
// R09: Zero to run clear parameter clears running hours; power-on never.
// R10: Running time credited only after one uninterrupted hour.
// R11: Run clear parameter always reads back 9999.
// R12: Decimal select zero shows whole units; below 0.99 shows zero.
// R13: Decimal select one drops hundredths; whole values unchanged.
// R14: Decimal select leaves hour monitors untouched.
// R15: Frequency full scale 0 to 400 Hz, initially 50 Hz.
// R16: Current full scale 0 to 500 A, initially rated current.
// R17: Meter code proportional to value over full scale, max 10 V.
// R18: Zero trim 970 to 1200, initially 1000.
// R19: Each zero trim step shifts output about 5 mV.
// R20: Meter output never below about -100 mV.
// R21: Meter settings writable whatever the write protect setting.
// R22: Meter settings accessible only when user group select is zero.
// R23: Operator does gain calibration after any zero calibration.
// R24: Gain trim scales full scale value to 10 V.
// R25: Power integrated each second so no energy is lost.
// R26: Hour ticks from hidden prescaler on internal time base.
module uam_top #(
   parameter int CYC_SEC = uam_pkg::CYC_PER_SEC,
   parameter int SEC_HOUR = uam_pkg::SEC_PER_HOUR,
   parameter logic [15:0] RATED_CUR = 16'h0320
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic drive_running,
   input wire logic [15:0] out_power,
   input wire logic [15:0] out_freq,
   input wire logic [15:0] out_current,
   input wire logic [15:0] ext_monitor,
   input wire logic [1:0] ext_monitor_dp,
   output logic [15:0] disp_value_ff,
   output logic [1:0] disp_dp_ff,
   output logic signed [15:0] meter_voltage_output_ff
);
   // Drops decimals as the decimal digit select asks
   function automatic logic [17:0] fmt_dec(input logic [15:0] v,
         input logic [1:0] dp, input logic [15:0] sel);
      logic [17:0] r;
      r = {v, dp};
      if (sel == uam_pkg::CODE_ZERO && dp == 2'd1)
         r = {16'(v / 16'd10), 2'd0};
      else if (sel == uam_pkg::CODE_ZERO && dp == 2'd2)
         r = {16'(v / 16'd100), 2'd0};
      else if (sel == uam_pkg::CODE_ONE && dp == 2'd2)
         r = {16'(v / 16'd10), 2'd1};
      return r;
   endfunction

   function automatic logic meter_reg(input logic [7:0] a);
      return a == uam_pkg::REG_FREQ_FS || a == uam_pkg::REG_CUR_FS ||
         a == uam_pkg::REG_ZERO_TRIM || a == uam_pkg::REG_GAIN_TRIM;
   endfunction

   logic aw_got_ff, w_got_ff;
   logic [7:0] awaddr_ff;
   logic [15:0] wdata_ff;
   logic [15:0] energy_mode_ff, dec_sel_ff, disp_sel_ff, freq_fs_ff;
   logic [15:0] cur_fs_ff, zero_trim_ff, gain_trim_ff, user_grp_ff;
   logic [15:0] wr_prot_ff, meter_item_ff;
   logic [31:0] sec_cnt_ff;
   logic [15:0] hour_sec_ff, run_sec_ff;
   logic sec_tick_ff, hour_tick_ff, run_tick_ff;
   logic [19:0] energy_tot_ff, energy_shown_ff;
   logic [15:0] energy_frac_ff;
   logic [15:0] pon_hours, pon_tally, run_hours, run_tally;
   logic [15:0] comm_kwh;
   logic [19:0] shown_kwh;

   // Write path: address and data taken in either order
   wire do_wr = aw_got_ff && w_got_ff && !s_axi_bvalid;
   wire meter_ok = user_grp_ff == uam_pkg::CODE_ZERO;
   wire gen_ok = wr_prot_ff != uam_pkg::CODE_ONE;
   wire wr_map = awaddr_ff[1:0] == 2'b00 && awaddr_ff <= uam_pkg::REG_WR_PROT
      || awaddr_ff == uam_pkg::REG_METER_ITEM;
   wire wr_meter = do_wr && meter_ok && meter_reg(awaddr_ff); // R22
   wire wr_gen = do_wr && gen_ok;
   wire energy_clr = wr_gen && awaddr_ff == uam_pkg::REG_ENERGY_CLR
      && wdata_ff == uam_pkg::CODE_ZERO;
   wire run_clr = wr_gen && awaddr_ff == uam_pkg::REG_RUN_CLR
      && wdata_ff == uam_pkg::CODE_ZERO;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_got_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata[15:0];
         end else if (do_wr) begin
            w_got_ff <= 1'b0;
         end
      end
   end

   // Ready only while the slot is empty; one write at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= uam_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_got_ff && !(s_axi_awvalid && s_axi_awready)
            && !s_axi_bvalid && !do_wr;
         s_axi_wready <= !w_got_ff && !(s_axi_wvalid && s_axi_wready)
            && !s_axi_bvalid && !do_wr;
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? uam_pkg::RESP_OKAY : uam_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // General settings; out of range energy clear and decimal select values are ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         energy_mode_ff <= uam_pkg::CODE_OFF;
         dec_sel_ff <= uam_pkg::CODE_OFF;
         disp_sel_ff <= uam_pkg::CODE_ZERO;
         user_grp_ff <= uam_pkg::CODE_ZERO;
         wr_prot_ff <= uam_pkg::CODE_ZERO;
         meter_item_ff <= uam_pkg::ITEM_FREQ;
      end else if (wr_gen) begin
         unique case (awaddr_ff)
            uam_pkg::REG_ENERGY_CLR:
               if (wdata_ff == uam_pkg::CODE_OFF ||
                   wdata_ff == uam_pkg::CODE_TEN)
                  energy_mode_ff <= wdata_ff; // R04
            uam_pkg::REG_DEC_SEL:
               if (wdata_ff == uam_pkg::CODE_OFF ||
                   wdata_ff <= uam_pkg::CODE_ONE)
                  dec_sel_ff <= wdata_ff;
            uam_pkg::REG_DISP_SEL: disp_sel_ff <= wdata_ff;
            uam_pkg::REG_USER_GRP: user_grp_ff <= wdata_ff;
            uam_pkg::REG_METER_ITEM: meter_item_ff <= wdata_ff;
            default: ;
         endcase
      end
      if (aresetn && do_wr && awaddr_ff == uam_pkg::REG_WR_PROT)
         wr_prot_ff <= wdata_ff;
   end

   // Meter settings bypass write protect
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         freq_fs_ff <= uam_pkg::FREQ_FS_RST; // R15
         cur_fs_ff <= RATED_CUR; // R16
         zero_trim_ff <= uam_pkg::ZERO_TRIM_RST; // R18
         gain_trim_ff <= uam_pkg::GAIN_TRIM_RST;
      end else if (wr_meter) begin // R21
         unique case (awaddr_ff)
            uam_pkg::REG_FREQ_FS:
               if (wdata_ff <= uam_pkg::FREQ_FS_MAX) freq_fs_ff <= wdata_ff;
            uam_pkg::REG_CUR_FS:
               if (wdata_ff <= uam_pkg::CUR_FS_MAX) cur_fs_ff <= wdata_ff;
            uam_pkg::REG_ZERO_TRIM:
               if (wdata_ff >= uam_pkg::ZERO_TRIM_MIN &&
                   wdata_ff <= uam_pkg::ZERO_TRIM_MAX)
                  zero_trim_ff <= wdata_ff; // R18
            uam_pkg::REG_GAIN_TRIM:
               if (wdata_ff <= uam_pkg::GAIN_TRIM_MAX)
                  gain_trim_ff <= wdata_ff;
            default: ;
         endcase
      end
   end

   // Read path, one cycle after the address is taken
   logic [31:0] rd_word;
   always_comb begin
      rd_word = '0;
      unique case (s_axi_araddr)
         uam_pkg::REG_ENERGY_CLR: rd_word[15:0] = energy_mode_ff; // R04
         uam_pkg::REG_RUN_CLR: rd_word[15:0] = uam_pkg::CODE_OFF; // R11
         uam_pkg::REG_DEC_SEL: rd_word[15:0] = dec_sel_ff;
         uam_pkg::REG_DISP_SEL: rd_word[15:0] = disp_sel_ff;
         uam_pkg::REG_FREQ_FS: rd_word[15:0] = meter_ok ? freq_fs_ff : '0;
         uam_pkg::REG_CUR_FS: rd_word[15:0] = meter_ok ? cur_fs_ff : '0;
         uam_pkg::REG_ZERO_TRIM: rd_word[15:0] = meter_ok ? zero_trim_ff : '0;
         uam_pkg::REG_GAIN_TRIM: rd_word[15:0] = meter_ok ? gain_trim_ff : '0;
         uam_pkg::REG_USER_GRP: rd_word[15:0] = user_grp_ff;
         uam_pkg::REG_WR_PROT: rd_word[15:0] = wr_prot_ff;
         uam_pkg::REG_METER_ITEM: rd_word[15:0] = meter_item_ff;
         uam_pkg::REG_ENERGY: rd_word[15:0] = comm_kwh;
         uam_pkg::REG_PON_HRS: rd_word[15:0] = pon_hours;
         uam_pkg::REG_RUN_HRS: rd_word[15:0] = run_hours;
         uam_pkg::REG_PON_TALLY: rd_word[15:0] = pon_tally; // R08
         uam_pkg::REG_RUN_TALLY: rd_word[15:0] = run_tally; // R08
         default: rd_word = '0;
      endcase
   end

   always_comb begin
      shown_kwh = 20'(energy_shown_ff / 20'd100);
      comm_kwh = shown_kwh[15:0];
      if (energy_mode_ff == uam_pkg::CODE_TEN &&
          shown_kwh > 20'(uam_pkg::COMM_TEN_MAX))
         comm_kwh = uam_pkg::COMM_TEN_MAX;
   end

   wire rd_map = s_axi_araddr[1:0] == 2'b00 &&
      s_axi_araddr <= uam_pkg::REG_RUN_TALLY;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= uam_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_map ? uam_pkg::RESP_OKAY : uam_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Second and hour ticks; hour phase kept in a hidden prescaler
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sec_cnt_ff <= '0;
         sec_tick_ff <= 1'b0;
      end else begin
         sec_tick_ff <= sec_cnt_ff == 32'(CYC_SEC - 1);
         sec_cnt_ff <= sec_cnt_ff == 32'(CYC_SEC - 1) ? '0 : sec_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hour_sec_ff <= '0;
         hour_tick_ff <= 1'b0;
      end else begin
         hour_tick_ff <= 1'b0;
         if (sec_tick_ff) begin
            hour_sec_ff <= hour_sec_ff + 1'b1; // R26
            if (hour_sec_ff == 16'(SEC_HOUR - 1)) begin
               hour_sec_ff <= '0;
               hour_tick_ff <= 1'b1;
            end
         end
      end
   end

   // Running span restarts on any stop, so short runs earn nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_sec_ff <= '0;
         run_tick_ff <= 1'b0;
      end else begin
         run_tick_ff <= 1'b0;
         if (!drive_running) begin
            run_sec_ff <= '0; // R10
         end else if (sec_tick_ff) begin
            run_sec_ff <= run_sec_ff + 1'b1; // R06
            if (run_sec_ff == 16'(SEC_HOUR - 1)) begin
               run_sec_ff <= '0;
               run_tick_ff <= 1'b1;
            end
         end
      end
   end

   uam_hour_ctr #(.WIDTH(16)) u_pon (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(hour_tick_ff), // R05
      .clr(1'b0), // R09
      .hours_ff(pon_hours),
      .tally_ff(pon_tally)
   );

   uam_hour_ctr #(.WIDTH(16)) u_run (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(run_tick_ff), // R06
      .clr(run_clr), // R09
      .hours_ff(run_hours),
      .tally_ff(run_tally)
   );

   // Energy: per-second integration, remainder carried
   wire [16:0] frac_sum = 17'(energy_frac_ff) + 17'(out_power);
   wire [16:0] frac_units = 17'(frac_sum / 17'(uam_pkg::KWS_PER_UNIT));
   wire [16:0] frac_rem = 17'(frac_sum % 17'(uam_pkg::KWS_PER_UNIT));
   wire [20:0] tot_sum = 21'(energy_tot_ff) + 21'(frac_units);

   always_ff @(posedge aclk) begin
      if (!aresetn || energy_clr) begin
         energy_tot_ff <= '0; // R03
         energy_frac_ff <= '0;
      end else if (sec_tick_ff) begin
         energy_frac_ff <= frac_rem[15:0]; // R25
         energy_tot_ff <= tot_sum > 21'(uam_pkg::ENERGY_MAX) ?
            uam_pkg::ENERGY_MAX : tot_sum[19:0]; // R02
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || energy_clr) begin
         energy_shown_ff <= '0; // R03
      end else if (hour_tick_ff) begin
         energy_shown_ff <= energy_tot_ff; // R01
      end
   end

   // Panel: four digits, point moves as energy grows
   logic [17:0] energy_fmt, panel;
   always_comb begin
      if (energy_shown_ff < uam_pkg::ENERGY_TWO_DP)
         energy_fmt = {energy_shown_ff[15:0], 2'd2}; // R02
      else if (energy_shown_ff < uam_pkg::ENERGY_ONE_DP)
         energy_fmt = {16'(energy_shown_ff / 20'd10), 2'd1};
      else
         energy_fmt = {16'(energy_shown_ff / 20'd100), 2'd0};
      unique case (disp_sel_ff)
         uam_pkg::SEL_PON: panel = {pon_hours, 2'd0}; // R14
         uam_pkg::SEL_RUN: panel = {run_hours, 2'd0}; // R14
         uam_pkg::SEL_ENERGY:
            panel = fmt_dec(energy_fmt[17:2], energy_fmt[1:0], dec_sel_ff);
         default: panel = fmt_dec(ext_monitor, ext_monitor_dp,
            dec_sel_ff); // R12 R13
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         disp_value_ff <= '0;
         disp_dp_ff <= '0;
      end else begin
         disp_value_ff <= panel[17:2];
         disp_dp_ff <= panel[1:0];
      end
   end

   // Meter: value over full scale, gain in per mille, trim in 5 mV steps
   logic [15:0] mon, fs;
   logic [31:0] ratio;
   // Wide enough for a tiny full scale at maximum gain
   logic signed [43:0] mv;
   always_comb begin
      mon = meter_item_ff == uam_pkg::ITEM_CUR ? out_current : out_freq;
      fs = meter_item_ff == uam_pkg::ITEM_CUR ? cur_fs_ff : freq_fs_ff;
      ratio = fs == '0 ? 32'(uam_pkg::METER_FS_MV) :
         32'(32'(mon) * 32'(uam_pkg::METER_FS_MV) / 32'(fs)); // R17
      mv = 44'(ratio) * 44'(gain_trim_ff) / 44'(uam_pkg::TRIM_CENTRE); // R24
      mv = mv + (44'(zero_trim_ff) - 44'(uam_pkg::TRIM_CENTRE))
         * 44'(uam_pkg::TRIM_STEP_MV); // R19
      if (mv > 44'(uam_pkg::METER_FS_MV))
         mv = 44'(uam_pkg::METER_FS_MV); // R17
      if (mv < 44'(uam_pkg::METER_MIN_MV))
         mv = 44'(uam_pkg::METER_MIN_MV); // R20
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meter_voltage_output_ff <= '0;
      end else begin
         meter_voltage_output_ff <= mv[15:0];
      end
   end

   energy_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      energy_clr |=> energy_tot_ff == '0 && energy_shown_ff == '0)
      else $error("energy not cleared"); // R03
   energy_hourly_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !hour_tick_ff && !energy_clr |=> $stable(energy_shown_ff))
      else $error("energy shown off the hour"); // R01
   mode_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == uam_pkg::REG_ENERGY_CLR |=> s_axi_rvalid &&
      (s_axi_rdata == 32'(uam_pkg::CODE_OFF) ||
       s_axi_rdata == 32'(uam_pkg::CODE_TEN)))
      else $error("energy clear read not a mode"); // R04
   run_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == uam_pkg::REG_RUN_CLR |=>
      s_axi_rdata == 32'(uam_pkg::CODE_OFF))
      else $error("run clear read not 9999"); // R11
   meter_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
      meter_voltage_output_ff <= 16'(uam_pkg::METER_FS_MV) &&
      meter_voltage_output_ff >= 16'(uam_pkg::METER_MIN_MV))
      else $error("meter out of range"); // R20
   short_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !drive_running |=> !run_tick_ff ##1 !run_tick_ff)
      else $error("run credited after stop"); // R10
   trim_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
      zero_trim_ff >= uam_pkg::ZERO_TRIM_MIN &&
      zero_trim_ff <= uam_pkg::ZERO_TRIM_MAX)
      else $error("zero trim out of range"); // R18
   group_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
      user_grp_ff != uam_pkg::CODE_ZERO |=> $stable(freq_fs_ff) &&
      $stable(cur_fs_ff) && $stable(zero_trim_ff))
      else $error("meter setting changed while locked"); // R22
endmodule // uam_top
`default_nettype wire

// file: verification/uam_bench.sv
// Self-checking bench for the usage accumulator and meter scaling block.
// Assumes uam_top with one hour shortened to 16 clocks.
`timescale 1ns/1ps
`default_nettype none
module usage_accumulators_and_meter_scaling_test;
   logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid;
   logic rready, awready, wready, arready, run;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, got;
   logic [1:0] bresp, rresp, rs, dp, mdp;
   logic [15:0] fq, mon, disp, pw;
   logic signed [15:0] mv;
   int fail_count, checks_done, a, b;
   uam_top #(.CYC_SEC(4), .SEC_HOUR(4)) uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_running(run),
      .out_power(pw), .out_freq(fq), .out_current(16'h0100),
      .ext_monitor(mon), .ext_monitor_dp(mdp), .disp_value_ff(disp),
      .disp_dp_ff(dp), .meter_voltage_output_ff(mv));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // Both channels offered together, each released once taken
   task automatic wr(input logic [7:0] ad, input logic [15:0] d);
      @(posedge aclk);
      awaddr <= ad;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad);
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      got = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
      rd(ad);
      chk(got, e);
   endtask
   // Outputs are registered; three edges leave margin for the setting path
   task automatic ochk(input int e, input logic [17:0] dd);
      repeat (3) @(posedge aclk);
      if (e < 20000) chk(32'(mv), 32'(e));
      else chk({14'h0000, dp, disp}, {14'h0000, dd});
   endtask
   function automatic int mvx(int m, int fs, int tr, int g);
      int v;
      v = m * 10000 / fs * g / 1000 + (tr - 1000) * 5;
      return v > 10000 ? 10000 : (v < -100 ? -100 : v);
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      final_report();
   end
   initial begin
      int tr[3] = '{970, 1010, 1200};
      {aresetn, awvalid, wvalid, bready, arvalid, rready, run} = '0;
      {awaddr, araddr, wdata, fq, mon, mdp, pw} = '0;
      void'($urandom(32'hd752b3dd));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(uam_pkg::REG_ENERGY_CLR, 32'h270f);
      wr(uam_pkg::REG_ENERGY_CLR, 16'h0000);
      rchk(uam_pkg::REG_ENERGY_CLR, 32'h270f);
      rchk(uam_pkg::REG_ENERGY, 32'h0);
      wr(uam_pkg::REG_RUN_CLR, 16'h0000);
      rchk(uam_pkg::REG_RUN_CLR, 32'h270f);
      rchk(uam_pkg::REG_FREQ_FS, 32'h1388);
      rchk(uam_pkg::REG_CUR_FS, 32'h0320);
      rchk(uam_pkg::REG_ZERO_TRIM, 32'h03e8);
      rd(8'h80);
      chk(32'(rs), 32'(uam_pkg::RESP_SLVERR));
      wr(uam_pkg::REG_USER_GRP, 16'h0001);
      rchk(uam_pkg::REG_FREQ_FS, 32'h0);
      wr(uam_pkg::REG_USER_GRP, 16'h0000);
      wr(uam_pkg::REG_WR_PROT, 16'h0001);
      wr(uam_pkg::REG_FREQ_FS, 16'h2710);
      rchk(uam_pkg::REG_FREQ_FS, 32'h2710);
      wr(uam_pkg::REG_WR_PROT, 16'h0000);
      $display("registers done");
      repeat (6) begin
         a = $urandom_range(0, 12000);
         fq <= 16'(a);
         ochk(mvx(a, 10000, 1000, 1000), 18'h0);
      end
      fq <= 16'h0000;
      foreach (tr[i]) begin
         wr(uam_pkg::REG_ZERO_TRIM, 16'(tr[i]));
         ochk(mvx(0, 10000, tr[i], 1000), 18'h0);
      end
      wr(uam_pkg::REG_ZERO_TRIM, 16'h03e8);
      wr(uam_pkg::REG_GAIN_TRIM, 16'h05dc);
      a = $urandom_range(0, 12000);
      fq <= 16'(a);
      ochk(mvx(a, 10000, 1000, 1500), 18'h0);
      wr(uam_pkg::REG_METER_ITEM, uam_pkg::ITEM_CUR);
      ochk(mvx(256, 800, 1000, 1500), 18'h0);
      $display("meter done");
      mon <= 16'd12345;
      mdp <= 2'd2;
      wr(uam_pkg::REG_DEC_SEL, uam_pkg::CODE_ONE);
      ochk(20000, {2'd1, 16'd1234});
      wr(uam_pkg::REG_DEC_SEL, uam_pkg::CODE_ZERO);
      ochk(20000, {2'd0, 16'd123});
      mon <= 16'd99;
      ochk(20000, 18'h0);
      $display("decimals done");
      wr(uam_pkg::REG_DEC_SEL, uam_pkg::CODE_OFF);
      wr(uam_pkg::REG_DISP_SEL, uam_pkg::SEL_ENERGY);
      // Ten units a second leaves no remainder; 4000 clocks hold 1000 seconds
      pw <= 16'h8ca0;
      repeat (4000) @(posedge aclk);
      pw <= 16'h0000;
      repeat (40) @(posedge aclk);
      ochk(20000, {2'd1, 16'd1000});
      rchk(uam_pkg::REG_ENERGY, 32'd100);
      wr(uam_pkg::REG_ENERGY_CLR, 16'h0000);
      ochk(20000, {2'd2, 16'd0});
      $display("energy done");
      run <= 1'b1;
      repeat (80) @(posedge aclk);
      run <= 1'b0;
      // 80 running clocks hold exactly 20 second ticks
      rchk(uam_pkg::REG_RUN_HRS, 32'd5);
      rd(uam_pkg::REG_PON_HRS);
      b = int'(got);
      wr(uam_pkg::REG_RUN_CLR, 16'h0000);
      rchk(uam_pkg::REG_RUN_HRS, 32'h0);
      repeat (6) begin
         run <= 1'b1;
         repeat (12) @(posedge aclk);
         run <= 1'b0;
         repeat (4) @(posedge aclk);
      end
      rchk(uam_pkg::REG_RUN_HRS, 32'h0);
      rd(uam_pkg::REG_PON_HRS);
      chk(32'(int'(got) >= b + 5), 32'h1);
      $display("hours done");
      final_report();
   end
endmodule // usage_accumulators_and_meter_scaling_test
`default_nettype wire
